// File: core/pmews_top.sv
// PME wake signalling block: wake detection, PME pin drive, reset-time mode choice
//
// How it works
// - PME mode only entered when the loaded power method flag says self powered.
// - Mode select pin sampled on the cycle chip reset goes low; decides PME or normal.
// - Internal PHY: pin 0 drives PME, pin 1 is mode select.
// - External PHY: pin 8 drives PME, pin 9 is mode select.
// - PHY source select level picks the internal or external pin assignment.
// - A non-reserved pin wakes only while its direction is input.
// - A pin wakes only when its wake enable bit is set.
// - Any reset clears the direction register to all inputs; wake enables load from configuration memory.
// - In PME mode the two reserved pins keep signalling regardless of register values.
// - Wake pins are 2 to 10 internally, only 10 externally.
// - Pin 10 sense follows loaded flag; pins 2 to 9 default active low.
// - Magic packet in PME mode asserts PME.
// - Link partner detect in PME mode asserts PME.
// - PME needs enable flag; flags pick pulse/level, length, polarity, buffer, LAN source.
// - Mode select 1 keeps PME mode, 0 resumes normal, acted on at clear.
// - No interrupt bits, no software clear, GPIO registers locked during PME mode.
// - In PME mode any reset reloads the configuration memory.
// - Power-on with mode select 1 and enabled memory goes straight to PME mode.
// - Flag decode: level=0, polarity 1 high, buffer 1 push-pull, LAN 0 magic, det 0 low.
// - External PHY link indicator on pin 10 wakes through the pin path.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module pmews_top
    import pmews_pkg::*;
(
    // Clock and power-on reset
    input  wire logic               i_mclk,
    input  wire logic               i_reset_n,
    // Chip reset, also the Wake_clear_in
    input  wire logic               i_chip_reset_n,
    // Strap
    input  wire logic               i_phy_source_select,
    // Configuration memory load
    input  wire logic               i_eeprom_done,
    input  wire logic               i_eeprom_present,
    input  wire pmews_flags_t       i_eeprom_flags,
    input  wire logic [10:0]        i_eeprom_wake_en,
    output logic                    o_eeprom_load,
    // LAN wake sources
    input  wire logic               i_magic_packet,
    input  wire logic               i_link_up,
    // GPIO pins
    input  wire logic [10:0]        i_gpio_in,
    output logic [10:0]             o_gpio_out,
    output logic [10:0]             o_gpio_oe,
    // Register port
    input  wire logic [7:0]         i_reg_addr,
    input  wire logic [31:0]        i_reg_wdata,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    output logic [31:0]             o_reg_rdata,
    // Status
    output logic                    o_pme_mode
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ----------------------------------------------------------------
    // Pin wake detection
    // ----------------------------------------------------------------
    pmews_state_t st;
    pmews_state_t next_st;
    logic         phy_ext;
    logic [10:0]  wake_ok;
    logic [10:0]  pin_hit;

    assign phy_ext = i_phy_source_select;
    assign wake_ok = phy_ext ? WAKE_OK_EXT : WAKE_OK_INT;

    genvar g;
    generate
        for (g = 0; g < NUM_GPIO; g++) begin : g_wake
            // Enabled, input, available and at its active level
            assign pin_hit[g] = st.wake_en[g] & ~st.gpio_dir[g] & wake_ok[g]
                              & (st.wake_pol[g] ? i_gpio_in[g] : ~i_gpio_in[g]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0]  pme_idx;
        logic [3:0]  sel_idx;
        logic        sel_pin;
        logic        keep;
        logic        lan_hit;
        logic        wake;
        logic        wake_evt;
        logic        in_pme;
        logic        pme_act;
        logic        pme_lvl;
        logic [10:0] pol_dflt;
        pme_idx  = phy_ext ? PIN_PME_EXT : PIN_PME_INT;
        sel_idx  = phy_ext ? PIN_SEL_EXT : PIN_SEL_INT;
        sel_pin  = i_gpio_in[sel_idx];
        keep     = st.por_first ? sel_pin : st.keep_pme;
        lan_hit  = st.flags.wol_link ? i_link_up : i_magic_packet;
        wake     = (|pin_hit) | lan_hit;
        wake_evt = wake & ~st.hit_prev;
        in_pme   = (st.mode == ST_PME_WAIT) || (st.mode == ST_PME_SIGNAL);
        pol_dflt = RST_WAKE_POL;
        pme_act  = (st.mode == ST_PME_SIGNAL);
        pme_lvl  = pme_act ? st.flags.pol_high : ~st.flags.pol_high;
        next_st  = st;

        next_st.por_first = 1'b0;
        next_st.keep_pme  = keep;
        next_st.chip_prev = i_chip_reset_n;
        next_st.hit_prev  = wake;
        next_st.rdata     = 32'h0000_0000;
        next_st.load_req  = 1'b0;

        unique case (st.mode)
            ST_LOAD: begin
                next_st.load_req = ~i_eeprom_done;
                if (i_eeprom_done) begin
                    next_st.flags    = i_eeprom_flags;
                    next_st.wake_en  = i_eeprom_wake_en;
                    pol_dflt[10]     = i_eeprom_flags.det10_high;
                    next_st.wake_pol = pol_dflt;
                    next_st.load_req = 1'b0;
                    // Enter PME only when every condition holds
                    if (keep && i_eeprom_present && i_eeprom_flags.pme_enable
                        && i_eeprom_flags.self_powered) begin
                        next_st.mode = ST_PME_WAIT;
                    end else begin
                        next_st.mode = ST_NORMAL;
                    end
                end
            end
            ST_NORMAL: begin
                if (i_reg_wr) begin
                    unique case (i_reg_addr)
                        REG_GPIO_DIR:  next_st.gpio_dir  = i_reg_wdata[10:0];
                        REG_GPIO_DATA: next_st.gpio_data = i_reg_wdata[10:0];
                        REG_WAKE: begin
                            next_st.wake_en  = i_reg_wdata[10:0];
                            next_st.wake_pol = i_reg_wdata[WAKE_POL_LSB +: 11];
                        end
                        default: ;
                    endcase
                end
            end
            ST_PME_WAIT: begin
                // Events go to the PME pin only, never to an interrupt flag
                if (wake_evt) begin
                    next_st.mode      = ST_PME_SIGNAL;
                    next_st.pulse_cnt = (st.flags.pulse_long ? PULSE_LONG_CYC
                                                             : PULSE_SHORT_CYC) - 12'h001;
                end
            end
            ST_PME_SIGNAL: begin
                // Level mode stays here until chip reset
                if (st.flags.pulse_mode) begin
                    if (st.pulse_cnt == 12'h000) begin
                        next_st.mode = ST_PME_WAIT;
                    end else begin
                        next_st.pulse_cnt = st.pulse_cnt - 12'h001;
                    end
                end
            end
        endcase

        // Register reads
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                REG_GPIO_DIR:  next_st.rdata = {21'h000000, st.gpio_dir};
                REG_GPIO_DATA: next_st.rdata = {21'h000000, i_gpio_in};
                REG_WAKE:      next_st.rdata = {5'h00, st.wake_pol, 5'h00, st.wake_en};
                REG_STATUS: begin
                    next_st.rdata[STS_PME_MODE] = in_pme;
                    next_st.rdata[STS_PME_OUT]  = (st.mode == ST_PME_SIGNAL);
                    next_st.rdata[STS_PHY_EXT]  = phy_ext;
                    next_st.rdata[STS_READY]    = (st.mode != ST_LOAD);
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Chip reset: sample mode select on assertion, then reload
        if (!i_chip_reset_n) begin
            if (st.chip_prev) begin
                next_st.keep_pme = sel_pin;
            end
            next_st.mode      = ST_LOAD;
            next_st.gpio_dir  = RST_GPIO_DIR;
            next_st.gpio_data = RST_GPIO_DATA;
            next_st.load_req  = 1'b0;
        end

        // Pin drive; reserved pins override registers in PME mode
        next_st.gpio_out = st.gpio_data;
        next_st.gpio_oe  = st.gpio_dir;
        if (in_pme || (st.mode == ST_LOAD && keep)) begin
            next_st.gpio_out[pme_idx] = pme_lvl;
            next_st.gpio_oe[pme_idx]  = st.flags.buf_push_pull | ~pme_lvl;
            next_st.gpio_out[sel_idx] = 1'b0;
            next_st.gpio_oe[sel_idx]  = 1'b0;
        end
        next_st.pme_mode = in_pme;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st.mode      <= ST_LOAD;
            st.por_first <= 1'b1;
            st.keep_pme  <= 1'b0;
            st.chip_prev <= 1'b1;
            st.hit_prev  <= 1'b0;
            st.flags     <= RST_FLAGS;
            st.gpio_dir  <= RST_GPIO_DIR;
            st.gpio_data <= RST_GPIO_DATA;
            st.wake_en   <= RST_WAKE_EN;
            st.wake_pol  <= RST_WAKE_POL;
            st.pulse_cnt <= 12'h000;
            st.gpio_out  <= 11'h000;
            st.gpio_oe   <= 11'h000;
            st.rdata     <= 32'h0000_0000;
            st.load_req  <= 1'b0;
            st.pme_mode  <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_gpio_out    = st.gpio_out;
    assign o_gpio_oe     = st.gpio_oe;
    assign o_reg_rdata   = st.rdata;
    assign o_eeprom_load = st.load_req;
    assign o_pme_mode    = st.pme_mode;

endmodule

`default_nettype wire

// File: core/pmews_pkg.sv
// Package for the PME wake signalling block: constants, flag layout, state record
package pmews_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int unsigned NUM_GPIO   = 11;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned CNT_W      = 12;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_GPIO_DIR  = 8'h00;
    localparam logic [7:0] REG_GPIO_DATA = 8'h04;
    localparam logic [7:0] REG_WAKE      = 8'h08;
    localparam logic [7:0] REG_STATUS    = 8'h0C;

    // Field positions
    localparam int unsigned WAKE_POL_LSB  = 16;
    localparam int unsigned STS_PME_MODE  = 0;
    localparam int unsigned STS_PME_OUT   = 1;
    localparam int unsigned STS_PHY_EXT   = 2;
    localparam int unsigned STS_READY     = 3;

    // ----------------------------------------------------------------
    // Pin assignment per PHY mode
    // ----------------------------------------------------------------
    localparam logic [3:0] PIN_PME_INT  = 4'h0;
    localparam logic [3:0] PIN_SEL_INT  = 4'h1;
    localparam logic [3:0] PIN_PME_EXT  = 4'h8;
    localparam logic [3:0] PIN_SEL_EXT  = 4'h9;
    localparam logic [10:0] WAKE_OK_INT = 11'h7FC;
    localparam logic [10:0] WAKE_OK_EXT = 11'h400;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [10:0] RST_GPIO_DIR  = 11'h000;
    localparam logic [10:0] RST_GPIO_DATA = 11'h000;
    localparam logic [10:0] RST_WAKE_EN   = 11'h000;
    localparam logic [10:0] RST_WAKE_POL  = 11'h000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned PULSE_SHORT_NS = 1000;
    localparam int unsigned PULSE_LONG_NS  = 50000;
    localparam logic [11:0] PULSE_SHORT_CYC = 12'(PULSE_SHORT_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_LONG_CYC  = 12'(PULSE_LONG_NS / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_LOAD       = 2'b00,
        ST_NORMAL     = 2'b01,
        ST_PME_WAIT   = 2'b10,
        ST_PME_SIGNAL = 2'b11
    } pmews_mode_t;

    // Signalling flags loaded from the configuration memory
    typedef struct packed {
        logic self_powered;
        logic wol_link;
        logic det10_high;
        logic buf_push_pull;
        logic pol_high;
        logic pulse_long;
        logic pulse_mode;
        logic pme_enable;
    } pmews_flags_t;

    localparam pmews_flags_t RST_FLAGS = 8'h00;

    // Whole state of the block
    typedef struct packed {
        pmews_mode_t  mode;
        logic         por_first;
        logic         keep_pme;
        logic         chip_prev;
        logic         hit_prev;
        pmews_flags_t flags;
        logic [10:0]  gpio_dir;
        logic [10:0]  gpio_data;
        logic [10:0]  wake_en;
        logic [10:0]  wake_pol;
        logic [11:0]  pulse_cnt;
        logic [10:0]  gpio_out;
        logic [10:0]  gpio_oe;
        logic [31:0]  rdata;
        logic         load_req;
        logic         pme_mode;
    } pmews_state_t;

endpackage

// File: bench/pmews_props.sv
// Checker for the PME wake signalling block ports
`timescale 1ns/1ps
`default_nettype none
module pmews_props
    import pmews_pkg::*;
(
    // Clock and resets
    input wire logic         i_mclk,
    input wire logic         i_reset_n,
    input wire logic         i_chip_reset_n,
    // Inputs watched
    input wire logic         i_eeprom_done,
    input wire pmews_flags_t i_eeprom_flags,
    input wire logic         i_reg_rd,
    input wire logic [7:0]   i_reg_addr,
    // Outputs watched
    input wire logic         o_eeprom_load,
    input wire logic [10:0]  o_gpio_oe,
    input wire logic [31:0]  o_reg_rdata,
    input wire logic         o_pme_mode
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    sequence s_load_taken;
        o_eeprom_load && i_eeprom_done;
    endsequence
    sequence s_rst_held;
        !i_chip_reset_n [*3];
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_bus_no_pme: assert property (s_load_taken ##0 !i_eeprom_flags.self_powered |-> ##2 !o_pme_mode)
        else $error("PME mode entered while bus powered");
    a_en_no_pme: assert property (s_load_taken ##0 !i_eeprom_flags.pme_enable |-> ##2 !o_pme_mode)
        else $error("PME mode entered without enable flag");
    a_load_ends: assert property (s_load_taken |=> !o_eeprom_load)
        else $error("Load request held after done");
    a_rst_holds: assert property (s_rst_held |-> !o_eeprom_load && !o_pme_mode)
        else $error("Chip reset did not hold the block");
    a_rst_inputs: assert property (s_rst_held |-> (o_gpio_oe & 11'h4FC) == 11'h000)
        else $error("Pin driven during chip reset");
    a_pme_pins: assert property (o_pme_mode |-> (o_gpio_oe & ~11'h101) == 11'h000)
        else $error("Non PME pin driven in PME mode");
    a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("Read data outside read slot");
    a_status_mode: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h0C
                                    |-> o_reg_rdata[0] == o_pme_mode)
        else $error("Status mode bit wrong");
endmodule

bind pmews_top pmews_props u_pmews_props (.i_mclk, .i_reset_n, .i_chip_reset_n, .i_eeprom_done,
    .i_eeprom_flags, .i_reg_rd, .i_reg_addr, .o_eeprom_load, .o_gpio_oe, .o_reg_rdata, .o_pme_mode);
`default_nettype wire

// File: bench/pmews_ec_model.sv
// Embedded power controller model: sets mode select, then pulses chip reset
`timescale 1ns/1ps
`default_nettype none
module pmews_ec_model (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    // Requests from the bench
    input  wire logic i_go,
    input  wire logic i_keep,
    // Lines to the device
    output logic      o_chip_reset_n,
    output logic      o_mode_select
);
    logic [3:0] step;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            step <= 4'h0;
            o_chip_reset_n <= 1'b1;
            o_mode_select <= 1'b1;
        end else if (step == 4'h0) begin
            if (i_go) begin
                step <= 4'h1;
                o_mode_select <= i_keep;
            end
        end else begin
            step <= (step == 4'h9) ? 4'h0 : step + 4'h1;
            o_chip_reset_n <= !(step >= 4'h3 && step < 4'h7);
        end
    end
endmodule
`default_nettype wire

// File: bench/pme_wake_signaling_test.sv
// Testbench for the PME wake signalling block
`timescale 1ns/1ps
`default_nettype none
module pme_wake_signaling_test;
    import pmews_pkg::*;
    localparam pmews_flags_t F_LVL = 8'h99;
    localparam pmews_flags_t F_PUL = 8'h9B;
    localparam pmews_flags_t F_EXT = 8'hD9;
    localparam pmews_flags_t F_BUS = 8'h19;
    localparam pmews_flags_t F_XPL = 8'hA7;
    logic mclk, rst_n, phy, done, magic, link, wr, rd, eload, pme, go, keep, chip_n, sel, present;
    logic [10:0]  pins, gin, wen, gout, goe;
    logic [7:0]   addr;
    logic [31:0]  wdata, rdata, rv;
    pmews_flags_t flags;
    int miscompares, check_count;

    pmews_top u_pmews_top (.i_mclk(mclk), .i_reset_n(rst_n), .i_chip_reset_n(chip_n),
        .i_phy_source_select(phy), .i_eeprom_done(done), .i_eeprom_present(present),
        .i_eeprom_flags(flags), .i_eeprom_wake_en(wen), .o_eeprom_load(eload),
        .i_magic_packet(magic), .i_link_up(link), .i_gpio_in(gin), .o_gpio_out(gout),
        .o_gpio_oe(goe), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_pme_mode(pme));
    pmews_ec_model u_pmews_ec_model (.i_mclk(mclk), .i_reset_n(rst_n), .i_go(go),
        .i_keep(keep), .o_chip_reset_n(chip_n), .o_mode_select(sel));

    always_comb begin
        gin = pins;
        gin[phy ? 9 : 1] = sel;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("Mismatches %0d of %0d checks", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_pin(input int p, input logic v, input int lim, output int n);
        n = 0;
        while (gout[p] !== v) begin
            if (n++ >= lim) begin
                miscompares++;
                end_sim();
            end
            @(posedge mclk);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic load(input pmews_flags_t f, input logic [10:0] w);
        int i;
        i = 0;
        while (eload !== 1'b1) begin
            if (i++ > 50) begin
                miscompares++;
                end_sim();
            end
            @(posedge mclk);
        end
        flags <= f;
        wen <= w;
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
        cyc(3);
    endtask
    task automatic clear(input logic k, input pmews_flags_t f, input logic [10:0] w);
        @(posedge mclk);
        keep <= k;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        cyc(12);
        load(f, w);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_power_pme;
        load(F_LVL, 11'h000);
        chk(pme, 1'b1);
        chk(gout[0], 1'b0);
        wr_reg(REG_GPIO_DIR, 32'h4);
        rd_reg(REG_GPIO_DIR);
        chk(rv, 32'h0);
        rd_reg(REG_STATUS);
        chk(rv, 32'h0000_0009);
    endtask
    task automatic t_magic_level;
        magic <= 1'b1;
        @(posedge mclk);
        magic <= 1'b0;
        cyc(3);
        chk({goe[0], gout[0]}, 2'b11);
        cyc(60);
        chk(gout[0], 1'b1);
        rd_reg(REG_STATUS);
        chk(rv, 32'h0000_000B);
    endtask
    task automatic t_pin_pulse;
        int n;
        clear(1'b1, F_PUL, 11'h004);
        chk(pme, 1'b1);
        pins[3] <= 1'b0;
        cyc(10);
        chk(gout[0], 1'b0);
        pins[2] <= 1'b0;
        wait_pin(0, 1'b1, 20, n);
        wait_pin(0, 1'b0, 100, n);
        chk(n, PULSE_SHORT_CYC);
        cyc(20);
        chk(gout[0], 1'b0);
        pins <= 11'h7FF;
    endtask
    task automatic t_resume;
        clear(1'b0, F_LVL, 11'h000);
        chk(pme, 1'b0);
        wr_reg(REG_GPIO_DIR, 32'h4);
        rd_reg(REG_GPIO_DIR);
        chk(rv, 32'h4);
        rd_reg(8'h40);
        chk(rv, 32'h0);
        clear(1'b0, F_LVL, 11'h000);
        rd_reg(REG_GPIO_DIR);
        chk(rv, 32'h0);
    endtask
    task automatic t_ext_link;
        phy <= 1'b1;
        clear(1'b1, F_EXT, 11'h000);
        chk(pme, 1'b1);
        chk(gout[8], 1'b0);
        link <= 1'b1;
        cyc(4);
        chk({goe[8], gout[8]}, 2'b11);
        chk(gout[0], 1'b0);
        clear(1'b1, F_BUS, 11'h000);
        chk(pme, 1'b0);
    endtask
    task automatic t_ext_pulse;
        int n;
        pins[10] <= 1'b0;
        clear(1'b1, F_XPL, 11'h400);
        chk(pme, 1'b1);
        chk({goe[8], gout[8]}, 2'b01);
        rd_reg(REG_WAKE);
        chk(rv, 32'h0400_0400);
        pins[10] <= 1'b1;
        wait_pin(8, 1'b0, 20, n);
        chk(goe[8], 1'b1);
        wait_pin(8, 1'b1, 2100, n);
        chk(n, PULSE_LONG_CYC);
    endtask
    task automatic t_por;
        @(posedge mclk);
        rst_n <= 1'b0;
        present <= 1'b0;
        cyc(4);
        rst_n <= 1'b1;
        load(F_LVL, 11'h000);
        chk(pme, 1'b0);
        present <= 1'b1;
        clear(1'b1, 8'h98, 11'h000);
        chk(pme, 1'b0);
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        {rst_n, phy, done, magic, link, wr, rd, go} = 8'h00;
        keep = 1'b1;
        present = 1'b1;
        pins = 11'h7FF;
        addr = 8'h00;
        wdata = 32'h0;
        wen = 11'h000;
        flags = 8'h00;
        miscompares = 0;
        check_count = 0;
        cyc(16);
        rst_n <= 1'b1;
        t_power_pme();
        t_magic_level();
        t_pin_pulse();
        t_resume();
        t_ext_link();
        t_ext_pulse();
        t_por();
        end_sim();
    end
endmodule
`default_nettype wire
